// ==== rtl/lsc_top.sv ====
// Module-side low-speed control: reset handling, attention, presence, power cap, serial access.
// Functional notes
// - Answer serial commands only while selected.
// - Host reads and writes memory over serial.
// - Long reset pulse restores all defaults.
// - Reset done: raise attention, clear not-ready.
// - Power-up posts completion without reset pulse.
// - Low-power request caps module power.
// - Presence line tied low when inserted.
// - Attention low flags faults or critical status.
// - Attention is open collector, pull-down only.
// - Fully functional within init time.
`timescale 1ns/100ps
`default_nettype none
module lsc_top #(
  parameter int unsigned INIT_CYCLES = lsc_pkg::INIT_CYCLES,
  parameter int unsigned RESET_PULSE_CYCLES = lsc_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic module_select_n_i,
  input  wire logic module_reset_n_i,
  input  wire logic low_power_request_i,
  input  wire logic fault_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      module_present_n_o,
  output logic      attention_n_o,
  output logic      attention_n_oe_o,
  output logic      power_cap_o,
  output logic      ready_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]                rst_sync;
    logic [2:0]                lp_sync;
    logic [2:0]                sel_sync;
    logic [2:0]                flt_sync;
    logic [lsc_pkg::CNT_W-1:0] cnt;
    logic [lsc_pkg::CNT_W-1:0] pulse_cnt;
    lsc_pkg::life_state_type   st;
    logic                      not_ready;
    logic                      attn;
    logic                      cap;
    logic                      clr;
    logic                      sel;
  } top_type;

  top_type t_r;
  top_type t_nxt;

  logic rst_low;
  logic rst_high;
  logic lp_lvl;
  logic flt_lvl;

  // Only the second and third stages are looked at; the first stays private.
  assign rst_low  = (t_r.rst_sync[2:1] == 2'b00);
  assign rst_high = (t_r.rst_sync[2:1] == 2'b11);
  assign lp_lvl   = t_r.lp_sync[2] & t_r.lp_sync[1];
  assign flt_lvl  = t_r.flt_sync[2] & t_r.flt_sync[1];

  always_comb begin
    t_nxt          = t_r;
    t_nxt.rst_sync = {t_r.rst_sync[1:0], module_reset_n_i};
    t_nxt.lp_sync  = {t_r.lp_sync[1:0], low_power_request_i};
    t_nxt.sel_sync = {t_r.sel_sync[1:0], ~module_select_n_i};
    t_nxt.flt_sync = {t_r.flt_sync[1:0], fault_i};
    t_nxt.clr      = 1'b0;
    if (t_r.sel_sync[2:1] == 2'b11) begin
      t_nxt.sel = 1'b1;
    end else if (t_r.sel_sync[2:1] == 2'b00) begin
      t_nxt.sel = 1'b0;
    end
    if (lp_lvl) begin
      t_nxt.cap = 1'b1;
    end else if (t_r.lp_sync[2:1] == 2'b00) begin
      t_nxt.cap = 1'b0;
    end
    // Short low pulses only count up; release before the limit leaves state alone.
    if (rst_low) begin
      if (t_r.pulse_cnt < lsc_pkg::CNT_W'(RESET_PULSE_CYCLES)) begin
        t_nxt.pulse_cnt = t_r.pulse_cnt + 1'b1;
      end
    end else if (rst_high) begin
      t_nxt.pulse_cnt = '0;
    end
    case (t_r.st)
      lsc_pkg::ST_INIT: begin
        // Power-up runs the same completion path as a pin reset.
        t_nxt.not_ready = 1'b1;
        t_nxt.cnt       = t_r.cnt + 1'b1;
        if (t_r.cnt >= lsc_pkg::CNT_W'(INIT_CYCLES - 1)) begin
          t_nxt.st        = lsc_pkg::ST_RUN;
          t_nxt.not_ready = 1'b0;
          t_nxt.attn      = 1'b1;
          t_nxt.cnt       = '0;
        end
      end
      lsc_pkg::ST_RUN: begin
        if (flt_lvl) begin
          t_nxt.attn = 1'b1;
        end
        if (t_r.pulse_cnt == lsc_pkg::CNT_W'(RESET_PULSE_CYCLES)) begin
          t_nxt.st        = lsc_pkg::ST_RESET;
          t_nxt.not_ready = 1'b1;
          t_nxt.attn      = 1'b0;
          t_nxt.clr       = 1'b1;
        end
      end
      lsc_pkg::ST_RESET: begin
        t_nxt.attn = 1'b0;
        if (rst_high) begin
          t_nxt.st = lsc_pkg::ST_INIT;
          t_nxt.cnt = '0;
        end
      end
      default: begin
        t_nxt.st = lsc_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_r <= '{rst_sync: 3'h7, st: lsc_pkg::ST_INIT, not_ready: 1'b1, cap: 1'b1, default: '0};
    end else begin
      t_r <= t_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and select cross into the serial clock domain as slow levels.
  logic [lsc_pkg::MEM_DW-1:0] status_word;
  logic                       ser_rst_n;
  logic                       ser_sel;
  lsc_pkg::mem_req_type       req;
  logic [lsc_pkg::MEM_DW-1:0] rdata;

  always_comb begin
    status_word = '0;
    status_word[lsc_pkg::DNR_BIT] = t_r.not_ready;
  end

  // A direct pin gate lets the slave stay quiet at once on deselect, with no clock needed.
  assign ser_sel   = ~module_select_n_i & ~t_r.not_ready;
  assign ser_rst_n = rst_n_i & ~t_r.clr;

  lsc_serial u_serial (
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .rst_n_i  (ser_rst_n),
    .sel_i    (ser_sel),
    .status_i (status_word),
    .sda_oe_o (sda_oe_o),
    .req_o    (req),
    .rdata_i  (rdata)
  );

  // The clear is armed by any serial reset and applied at the first serial clock after it.
  logic mem_clr_r;

  always_ff @(posedge scl_i or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      mem_clr_r <= 1'b1;
    end else begin
      mem_clr_r <= 1'b0;
    end
  end

  lsc_mem u_mem (
    .clk_i   (scl_i),
    .clr_i   (mem_clr_r),
    .req_i   (req),
    .rdata_o (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign sda_o              = 1'b0;
  assign module_present_n_o = 1'b0;
  assign attention_n_o      = 1'b0;
  assign attention_n_oe_o   = t_r.attn;
  assign power_cap_o        = t_r.cap;
  assign ready_o            = ~t_r.not_ready;

  ////////////////////////////////////////////////////////////////////////////
  done_attn_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st == lsc_pkg::ST_INIT && t_nxt.st == lsc_pkg::ST_RUN) |=> (attention_n_oe_o && ready_o))
    else $error("Completion did not raise attention and clear not-ready.");

  reset_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st == lsc_pkg::ST_RUN && t_r.pulse_cnt == lsc_pkg::CNT_W'(RESET_PULSE_CYCLES))
    |=> (t_r.st == lsc_pkg::ST_RESET && !ready_o))
    else $error("Long reset pulse did not start reset.");

  short_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st == lsc_pkg::ST_RUN && t_r.pulse_cnt < lsc_pkg::CNT_W'(RESET_PULSE_CYCLES)) |=>
    (t_r.st != lsc_pkg::ST_RESET))
    else $error("Short reset pulse started a reset.");

  not_ready_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st != lsc_pkg::ST_RUN) |-> !ready_o)
    else $error("Not-ready cleared before reset completed.");

  init_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st == lsc_pkg::ST_INIT) |-> (t_r.cnt < lsc_pkg::CNT_W'(INIT_CYCLES)))
    else $error("Initialization ran past its time.");

  power_cap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.lp_sync[2:1] == 2'b11) |=> power_cap_o)
    else $error("Power cap not applied on low-power request.");

  fault_attn_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (t_r.st == lsc_pkg::ST_RUN && flt_lvl && t_nxt.st == lsc_pkg::ST_RUN) |=> attention_n_oe_o)
    else $error("Fault did not pull attention low.");

  open_drain_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (attention_n_o == 1'b0 && module_present_n_o == 1'b0))
    else $error("Open-collector pin drove high.");

  deselect_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (module_select_n_i || !ready_o) |-> !sda_oe_o)
    else $error("Data line driven while deselected.");

endmodule
`default_nettype wire

// ==== rtl/lsc_pkg.sv ====
// Shared constants and carriers of the module low-speed control block.
package lsc_pkg;

  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  // Power-on initialization time in milliseconds.
  localparam int unsigned INIT_TIME_MS    = 2000;
  localparam longint unsigned INIT_CYCLES_L = longint'(INIT_TIME_MS) * longint'(SYS_CLK_HZ) / 64'd1000;
  localparam int unsigned INIT_CYCLES     = int'(INIT_CYCLES_L);
  // Minimum reset pulse length in microseconds.
  localparam int unsigned RESET_PULSE_US  = 10;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_US * (SYS_CLK_HZ / 1_000_000) > 0) ?
                                               RESET_PULSE_US * (SYS_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned MEM_AW          = 8;
  localparam int unsigned MEM_DW          = 8;
  localparam logic [6:0]  DEV_ADDR        = 7'h50;
  localparam logic [MEM_AW-1:0] STATUS_ADDR = 8'h02;
  localparam int unsigned DNR_BIT         = 0;
  localparam logic [MEM_DW-1:0] MEM_RESET_VAL = 8'h00;

  typedef enum {ST_INIT, ST_RUN, ST_RESET} life_state_type;

  // Memory access carrier between the serial slave and the memory.
  typedef struct packed {
    logic              wr;
    logic [MEM_AW-1:0] addr;
    logic [MEM_DW-1:0] wdata;
  } mem_req_type;

endpackage

// ==== rtl/lsc_mem.sv ====
// Small management memory with registered read data.
`timescale 1ns/100ps
`default_nettype none
module lsc_mem (
  input  wire logic                  clk_i,
  input  wire logic                  clr_i,
  input  wire lsc_pkg::mem_req_type  req_i,
  output logic [lsc_pkg::MEM_DW-1:0] rdata_o
);

  logic [lsc_pkg::MEM_DW-1:0] mem_r [0:(1<<lsc_pkg::MEM_AW)-1];

  // The array carries no reset; clearing walks every word at once on the clear strobe.
  genvar g;
  generate
    for (g = 0; g < (1<<lsc_pkg::MEM_AW); g++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (clr_i) begin
          mem_r[g] <= lsc_pkg::MEM_RESET_VAL;
        end else if (req_i.wr && req_i.addr == lsc_pkg::MEM_AW'(g)) begin
          mem_r[g] <= req_i.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_r[req_i.addr];
  end

endmodule
`default_nettype wire

// ==== rtl/lsc_serial.sv ====
// Two-wire serial slave running on the serial clock.
`timescale 1ns/100ps
`default_nettype none
module lsc_serial (
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      sel_i,
  input  wire logic [lsc_pkg::MEM_DW-1:0] status_i,
  output logic                           sda_oe_o,
  output lsc_pkg::mem_req_type           req_o,
  input  wire logic [lsc_pkg::MEM_DW-1:0] rdata_i
);

  typedef enum {S_IDLE, S_DEV, S_DACK, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK} ser_state_type;

  typedef struct packed {
    ser_state_type     st;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic [lsc_pkg::MEM_AW-1:0] addr;
    logic              rd;
    logic              oe;
    logic              wr;
  } ser_type;

  ser_type s_r;
  ser_type s_nxt;
  logic    start_tgl_r;
  logic    start_seen_r;
  logic    stop_tgl_r;
  logic    stop_seen_r;
  logic    start_r;
  logic    stop_r;
  logic    oe_r;

  // Start and stop toggle on data edges while the clock is high; the clock side marks them seen.
  // Toggles avoid a clear crossing back into the data-edge flops.
  always_ff @(negedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_tgl_r <= 1'b0;
    end else if (scl_i) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  always_ff @(posedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  assign start_r = start_tgl_r ^ start_seen_r;
  assign stop_r  = stop_tgl_r ^ stop_seen_r;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.wr = 1'b0;
    case (s_r.st)
      S_IDLE: begin
        s_nxt.oe = 1'b0;
      end
      S_DEV, S_ADDR, S_WDATA: begin
        s_nxt.shift   = {s_r.shift[6:0], sda_i};
        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      end
      S_RDATA: begin
        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      end
      default: begin
        s_nxt.bit_cnt = 4'h0;
      end
    endcase
    if (s_r.st == S_DEV && s_r.bit_cnt == 4'h7) begin
      s_nxt.st = (s_nxt.shift[7:1] == lsc_pkg::DEV_ADDR) ? S_DACK : S_IDLE;
      s_nxt.rd = s_nxt.shift[0];
    end else if (s_r.st == S_ADDR && s_r.bit_cnt == 4'h7) begin
      s_nxt.st   = S_AACK;
      s_nxt.addr = s_nxt.shift;
    end else if (s_r.st == S_WDATA && s_r.bit_cnt == 4'h7) begin
      s_nxt.st = S_WACK;
      s_nxt.wr = 1'b1;
    end else if (s_r.st == S_RDATA && s_r.bit_cnt == 4'h7) begin
      // Advance early so the registered memory word is ready for the next byte.
      s_nxt.st   = S_RACK;
      s_nxt.addr = s_r.addr + 8'h01;
    end else if (s_r.st == S_DACK) begin
      s_nxt.st = s_r.rd ? S_RDATA : S_ADDR;
    end else if (s_r.st == S_AACK || s_r.st == S_WACK) begin
      s_nxt.st   = S_WDATA;
      s_nxt.addr = (s_r.st == S_WACK) ? s_r.addr + 8'h01 : s_r.addr;
    end else if (s_r.st == S_RACK) begin
      s_nxt.st = sda_i ? S_IDLE : S_RDATA;
    end
    if (stop_r) begin
      s_nxt.st = S_IDLE;
    end
    // A start seen together with an older stop is the newer event and wins.
    if (start_r) begin
      s_nxt.st      = S_DEV;
      s_nxt.bit_cnt = 4'h1;
      s_nxt.shift   = {7'h00, sda_i};
    end
    if (!sel_i) begin
      s_nxt.st = S_IDLE;
    end
  end

  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r          <= '{st: S_IDLE, default: '0};
      start_seen_r <= 1'b0;
      stop_seen_r  <= 1'b0;
    end else begin
      s_r          <= s_nxt;
      start_seen_r <= start_tgl_r;
      stop_seen_r  <= stop_tgl_r;
    end
  end

  // Drive changes on the falling clock edge so data is steady while the clock is high.
  logic [lsc_pkg::MEM_DW-1:0] rd_word;
  assign rd_word = (s_r.addr == lsc_pkg::STATUS_ADDR) ? status_i : rdata_i;

  always_ff @(negedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_r <= 1'b0;
    end else if (!sel_i) begin
      oe_r <= 1'b0;
    end else if (s_r.st == S_DACK || s_r.st == S_AACK || s_r.st == S_WACK) begin
      oe_r <= 1'b1;
    end else if (s_r.st == S_RDATA) begin
      oe_r <= ~rd_word[3'd7 - s_r.bit_cnt[2:0]];
    end else begin
      oe_r <= 1'b0;
    end
  end

  // The serial clock may stop while deselected, so the release must not wait for it.
  assign sda_oe_o = oe_r & sel_i;

  assign req_o = '{wr: s_r.wr, addr: s_r.addr, wdata: s_r.shift};

endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host board model: two-wire serial master with the board pull-up on the data line.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic sda_dev_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic host_pull_r;

  // Either party may only pull low, so a released line reads high.
  assign sda_o = !(host_pull_r || sda_dev_oe_i);

  initial begin
    scl_o = 1'b1;
    host_pull_r = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The serial clock stands high between frames and has a 160 ns period inside them.
  task automatic bit_cycle(input logic pull, output logic seen);
    host_pull_r = pull;
    #40;
    scl_o = 1'b1;
    #40;
    seen = sda_o;
    #40;
    scl_o = 1'b0;
    #40;
  endtask

  task automatic start();
    host_pull_r = 1'b0;
    scl_o = 1'b1;
    #80;
    host_pull_r = 1'b1;
    #80;
    scl_o = 1'b0;
    #40;
  endtask

  task automatic stop();
    host_pull_r = 1'b1;
    #40;
    scl_o = 1'b1;
    #80;
    host_pull_r = 1'b0;
    #80;
  endtask

  // Bytes go out most significant bit first; the ninth clock carries the answer.
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(!b[i], s);
    end
    bit_cycle(1'b0, s);
    ack = !s;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(!last, s);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_module_low_speed_control.sv ====
// Self-checking testbench of the module low-speed control block.
`timescale 1ns/100ps
`default_nettype none
module test_module_low_speed_control;
  localparam int unsigned INIT_N  = 50;
  localparam int unsigned PULSE_N = 4;
  logic sys_clk_i, rst_n_i, module_select_n_i, module_reset_n_i, low_power_request_i, fault_i;
  logic scl, sda, sda_o, sda_oe, present_n, attn_n, attn_oe, power_cap, ready;
  int   failures, checks_done, cycles;
  logic attn_line;

  // The host board pulls the attention line up; the module only pulls it low.
  assign attn_line = !attn_oe;

  lsc_top #(.INIT_CYCLES(INIT_N), .RESET_PULSE_CYCLES(PULSE_N)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .module_select_n_i(module_select_n_i),
    .module_reset_n_i(module_reset_n_i), .low_power_request_i(low_power_request_i),
    .fault_i(fault_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .module_present_n_o(present_n), .attention_n_o(attn_n), .attention_n_oe_o(attn_oe),
    .power_cap_o(power_cap), .ready_o(ready));

  host_model host_u (.sda_dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // The ceiling sits far above the roughly 1200 cycles the scenarios need.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Waits for the completion post and judges the time it took against the init count.
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check("init time", 16'((n + 2 >= INIT_N) && (n <= INIT_N + 8)), 16'h0001);
    tick(2);
    check("attention after init", 16'(attn_line), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic write_two(input logic [7:0] off, input logic [15:0] d, output logic [3:0] acks);
    host_u.start();
    host_u.send(8'ha0, acks[3]);
    host_u.send(off, acks[2]);
    host_u.send(d[15:8], acks[1]);
    host_u.send(d[7:0], acks[0]);
    host_u.stop();
  endtask

  task automatic read_two(input logic [7:0] off, output logic [15:0] d, output logic [2:0] acks);
    host_u.start();
    host_u.send(8'ha0, acks[2]);
    host_u.send(off, acks[1]);
    host_u.stop();
    host_u.start();
    host_u.send(8'ha1, acks[0]);
    host_u.recv(1'b0, d[15:8]);
    host_u.recv(1'b1, d[7:0]);
    host_u.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic power_up_check();
    logic [15:0] d;
    logic [2:0]  a;
    check("ready during init", 16'(ready), 16'h0000);
    check("attention during init", 16'(attn_line), 16'h0001);
    wait_ready();
    check("presence", 16'(present_n), 16'h0000);
    check("data drive level", 16'(sda_o), 16'h0000);
    // The host learns the cause of the attention by reading the status byte.
    read_two(8'h02, d, a);
    check("status acks", 16'(a), 16'h0007);
    check("not ready flag", 16'(d[8]), 16'h0000);
  endtask

  task automatic memory_check();
    logic [15:0] d;
    logic [3:0]  w;
    logic [2:0]  a;
    write_two(8'h10, 16'ha53c, w);
    check("write acks", 16'(w), 16'h000f);
    read_two(8'h10, d, a);
    check("read back", d, 16'ha53c);
    @(posedge sys_clk_i) module_select_n_i <= 1'b1;
    write_two(8'h10, 16'hffff, w);
    check("deselected acks", 16'(w), 16'h0000);
    @(posedge sys_clk_i) module_select_n_i <= 1'b0;
    read_two(8'h10, d, a);
    check("ignored write", d, 16'ha53c);
  endtask

  task automatic power_check();
    @(posedge sys_clk_i) low_power_request_i <= 1'b1;
    tick(6);
    check("power cap on", 16'(power_cap), 16'h0001);
    @(posedge sys_clk_i) low_power_request_i <= 1'b0;
    tick(6);
    check("power cap off", 16'(power_cap), 16'h0000);
  endtask

  task automatic fault_check();
    @(posedge sys_clk_i) fault_i <= 1'b1;
    tick(3);
    check("attention on fault", 16'(attn_line), 16'h0000);
    @(posedge sys_clk_i) fault_i <= 1'b0;
  endtask

  // A pulse one cycle shorter than PULSE_N leaves the pulse filter two counts below its trigger.
  task automatic reset_pulse_check();
    logic [15:0] d;
    logic [2:0]  a;
    @(posedge sys_clk_i) module_reset_n_i <= 1'b0;
    tick(PULSE_N - 1);
    module_reset_n_i <= 1'b1;
    tick(10);
    check("short pulse ready", 16'(ready), 16'h0001);
    @(posedge sys_clk_i) module_reset_n_i <= 1'b0;
    tick(PULSE_N + 6);
    check("reset ready", 16'(ready), 16'h0000);
    check("reset attention", 16'(attn_line), 16'h0001);
    module_reset_n_i <= 1'b1;
    tick(4);
    check("not ready held", 16'(ready), 16'h0000);
    wait_ready();
    read_two(8'h10, d, a);
    check("defaults restored", d, 16'h0000);
    read_two(8'h02, d, a);
    check("flag after reset", 16'(d[8]), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Only one module sits on this bus, so a single select line serves it.
  initial begin
    rst_n_i = 1'b0;
    module_select_n_i = 1'b0;
    module_reset_n_i = 1'b1;
    low_power_request_i = 1'b1;
    fault_i = 1'b0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    tick(3);
    rst_n_i <= 1'b1;
    tick(2);
    power_up_check();
    memory_check();
    power_check();
    reset_pulse_check();
    fault_check();
    report_and_stop();
  end
endmodule
`default_nettype wire
